//--- hdl/sim_serial_pkg.sv
// Constants, register map and state types for the smart-card serial channel.
// Assumes a word-addressed Avalon-MM slave with 32-bit data and one 125 MHz clock.
package sim_serial_pkg;

    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W         = 3;
    localparam int unsigned DATA_W         = 32;
    localparam logic [2:0]  ADDR_TX_DATA   = 3'h0;
    localparam logic [2:0]  ADDR_RX_DATA   = 3'h1;
    localparam logic [2:0]  ADDR_MODE      = 3'h2;
    localparam logic [2:0]  ADDR_CTRL0     = 3'h3;
    localparam logic [2:0]  ADDR_CTRL1     = 3'h4;
    localparam logic [2:0]  ADDR_BAUD      = 3'h5;
    localparam logic [2:0]  ADDR_IRQ_STAT  = 3'h6;
    localparam logic [2:0]  ADDR_IRQ_MASK  = 3'h7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned RX_OVERRUN_BIT = 12;
    localparam int unsigned RX_FRAMING_BIT = 13;
    localparam int unsigned RX_PARITY_BIT  = 14;
    localparam int unsigned RX_SUM_BIT     = 15;
    localparam int unsigned MODE_PEN_BIT   = 0;
    localparam int unsigned MODE_PSEL_BIT  = 1;
    localparam int unsigned C0_ORDER_BIT   = 0;
    localparam int unsigned C0_TXEMPTY_BIT = 1;
    localparam int unsigned C1_TE_BIT      = 0;
    localparam int unsigned C1_RE_BIT      = 1;
    localparam int unsigned C1_INV_BIT     = 2;
    localparam int unsigned C1_ERE_BIT     = 3;
    localparam int unsigned C1_TBE_BIT     = 4;
    localparam int unsigned C1_RXC_BIT     = 5;
    localparam int unsigned IRQ_TX_BIT     = 0;
    localparam int unsigned IRQ_RX_BIT     = 1;
    localparam int unsigned IRQ_ERR_BIT    = 2;
    localparam int unsigned IRQ_W          = 3;

    // ----------------------------------------------------------------
    // Baud reset value, baud minimum and last data bit index
    // ----------------------------------------------------------------
    localparam logic [15:0] BAUD_RESET     = 16'h0010;
    localparam logic [15:0] BAUD_MIN       = 16'h0002;
    localparam logic [2:0]  LAST_DATA_BIT  = 3'h7;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_ERR} rx_state_t;

endpackage

//--- hdl/sim_card_serial_port.sv
// Smart-card serial channel: Avalon-MM register slave, transmitter, receiver
// with parity error signalling, and a read-cleared interrupt status.
// Assumes SERIAL_IN is synchronous to CLK and tied to the card line with SERIAL_OUT.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module sim_card_serial_port
    import sim_serial_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic [ADDR_W-1:0]   ADDRESS,
    input  wire logic                READ,
    input  wire logic                WRITE,
    input  wire logic [DATA_W-1:0]   WRITEDATA,
    output logic      [DATA_W-1:0]   READDATA,
    output logic                     WAITREQUEST,
    output logic                     IRQ,
    input  wire logic                SERIAL_IN,
    output logic                     SERIAL_OUT
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]         transmit_buffer_reg;
    logic               tbuf_full_reg;
    logic               parity_enable;
    logic               parity_select;
    logic               bit_order_select;
    logic               tx_enable;
    logic               rx_enable;
    logic               data_invert_select;
    logic               error_signal_enable;
    logic [15:0]        baud_reg;
    logic [IRQ_W-1:0]   irq_status_reg;
    logic [IRQ_W-1:0]   irq_mask_reg;
    logic [7:0]         receive_buffer_reg;
    logic               rx_full_reg;
    logic               overrun_reg;
    logic               framing_reg;
    logic               parity_err_reg;
    tx_state_t          tx_state;
    logic [15:0]        tx_cnt;
    logic [2:0]         tx_bitn;
    logic [7:0]         tx_shift;
    logic               tx_par;
    logic               tx_line;
    logic               tx_done;
    rx_state_t          rx_state;
    logic [15:0]        rx_cnt;
    logic [2:0]         rx_bitn;
    logic [7:0]         rx_shift;
    logic               rx_parbit;
    logic               rx_in_q;
    logic               rx_done;
    logic [7:0]         rx_word;
    logic               rx_fe;
    logic               rx_pe;
    logic               err_drive;
    logic [DATA_W-1:0]  rd_mux;
    logic [15:0]        baud_m1;
    logic [7:0]         tx_src;
    logic [7:0]         tx_rev;
    logic [7:0]         rx_rev;
    logic [7:0]         rx_ordered;
    logic               commit;
    logic               wr_commit;
    logic               rd_rx;
    logic               rd_stat;
    logic               tx_load;
    logic               tx_tick;
    logic               rx_tick;
    logic               line_perr;
    logic [IRQ_W-1:0]   irq_events;

    assign commit    = (READ | WRITE) & ~WAITREQUEST;
    assign wr_commit = WRITE & ~WAITREQUEST;
    assign rd_rx     = READ & ~WAITREQUEST & (ADDRESS == ADDR_RX_DATA);
    assign rd_stat   = READ & ~WAITREQUEST & (ADDRESS == ADDR_IRQ_STAT);
    assign baud_m1   = ((baud_reg < BAUD_MIN) ? BAUD_MIN : baud_reg) - 16'h0001;
    assign tx_tick   = (tx_cnt == 16'h0000);
    assign rx_tick   = (rx_cnt == 16'h0000);
    assign tx_load   = (tx_state == TX_IDLE) & tx_enable & tbuf_full_reg;

    // ----------------------------------------------------------------
    // Bit order and inversion
    // ----------------------------------------------------------------
    // Both directions shift LSB first on the line; MSB-first is a reversal.
    assign tx_src     = data_invert_select ? ~transmit_buffer_reg : transmit_buffer_reg;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_rev
            assign tx_rev[gi] = tx_src[7-gi];
            assign rx_rev[gi] = rx_shift[7-gi];
        end
    endgenerate
    assign rx_ordered = bit_order_select ? rx_rev : rx_shift;
    // Even select: line ones plus parity even; odd select: odd
    assign line_perr  = (^rx_shift) ^ rx_parbit ^ ~parity_select;

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // One wait cycle per access: read data is latched on the edge that drops waitrequest; writes take effect on the next edge.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            WAITREQUEST <= 1'b1;
        else if ((READ | WRITE) & WAITREQUEST)
            WAITREQUEST <= 1'b0;
        else
            WAITREQUEST <= 1'b1;
    end

    always_comb
    begin
        rd_mux = '0;
        case (ADDRESS)
            ADDR_TX_DATA:  rd_mux[7:0] = transmit_buffer_reg;
            ADDR_RX_DATA:
            begin
                rd_mux[7:0]            = receive_buffer_reg;
                rd_mux[RX_OVERRUN_BIT] = overrun_reg;
                rd_mux[RX_FRAMING_BIT] = framing_reg;
                rd_mux[RX_PARITY_BIT]  = parity_err_reg;
                rd_mux[RX_SUM_BIT]     = overrun_reg | framing_reg | parity_err_reg;
            end
            ADDR_MODE:
            begin
                rd_mux[MODE_PEN_BIT]  = parity_enable;
                rd_mux[MODE_PSEL_BIT] = parity_select;
            end
            ADDR_CTRL0:
            begin
                rd_mux[C0_ORDER_BIT]   = bit_order_select;
                rd_mux[C0_TXEMPTY_BIT] = (tx_state == TX_IDLE);
            end
            ADDR_CTRL1:
            begin
                rd_mux[C1_TE_BIT]  = tx_enable;
                rd_mux[C1_RE_BIT]  = rx_enable;
                rd_mux[C1_INV_BIT] = data_invert_select;
                rd_mux[C1_ERE_BIT] = error_signal_enable;
                rd_mux[C1_TBE_BIT] = ~tbuf_full_reg;
                rd_mux[C1_RXC_BIT] = rx_full_reg;
            end
            ADDR_BAUD:     rd_mux[15:0]      = baud_reg;
            ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_status_reg;
            ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
            default:       rd_mux = '0;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            READDATA <= '0;
        else if (READ & WAITREQUEST)
            READDATA <= rd_mux;
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            parity_enable       <= 1'b0;
            parity_select       <= 1'b0;
            bit_order_select    <= 1'b0;
            tx_enable           <= 1'b0;
            rx_enable           <= 1'b0;
            data_invert_select  <= 1'b0;
            error_signal_enable <= 1'b0;
            baud_reg            <= BAUD_RESET;
            irq_mask_reg        <= '0;
        end
        else if (wr_commit)
        begin
            case (ADDRESS)
                ADDR_MODE:
                begin
                    parity_enable <= WRITEDATA[MODE_PEN_BIT];
                    parity_select <= WRITEDATA[MODE_PSEL_BIT];
                end
                ADDR_CTRL0:    bit_order_select <= WRITEDATA[C0_ORDER_BIT];
                ADDR_CTRL1:
                begin
                    tx_enable           <= WRITEDATA[C1_TE_BIT];
                    rx_enable           <= WRITEDATA[C1_RE_BIT];
                    data_invert_select  <= WRITEDATA[C1_INV_BIT];
                    error_signal_enable <= WRITEDATA[C1_ERE_BIT];
                end
                ADDR_BAUD:     baud_reg     <= WRITEDATA[15:0];
                ADDR_IRQ_MASK: irq_mask_reg <= WRITEDATA[IRQ_W-1:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            transmit_buffer_reg <= 8'h00;
            tbuf_full_reg       <= 1'b0;
        end
        else if (wr_commit && ADDRESS == ADDR_TX_DATA)
        begin
            transmit_buffer_reg <= WRITEDATA[7:0];
            tbuf_full_reg       <= 1'b1;
        end
        else if (tx_load)
            tbuf_full_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 16'h0000;
            tx_bitn  <= 3'h0;
            tx_shift <= 8'h00;
            tx_par   <= 1'b0;
            tx_line  <= 1'b1;
            tx_done  <= 1'b0;
        end
        else
        begin
            tx_done <= 1'b0;
            tx_cnt  <= tx_tick ? baud_m1 : tx_cnt - 16'h0001;
            case (tx_state)
                TX_IDLE:
                begin
                    tx_line <= 1'b1;
                    tx_cnt  <= baud_m1;
                    if (tx_load)
                    begin
                        tx_shift <= bit_order_select ? tx_rev : tx_src;
                        tx_par   <= (^tx_src) ^ ~parity_select;
                        tx_line  <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START:
                    if (tx_tick)
                    begin
                        tx_line  <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bitn  <= 3'h0;
                        tx_state <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_tick)
                    begin
                        if (tx_bitn == LAST_DATA_BIT)
                        begin
                            tx_line  <= parity_enable ? tx_par : 1'b1;
                            tx_state <= parity_enable ? TX_PAR : TX_STOP;
                        end
                        else
                        begin
                            tx_line  <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_bitn  <= tx_bitn + 3'h1;
                        end
                    end
                TX_PAR:
                    if (tx_tick)
                    begin
                        tx_line  <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                TX_STOP:
                    if (tx_tick)
                    begin
                        tx_done  <= 1'b1;
                        tx_state <= TX_IDLE;
                    end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receiver and error signal
    // ----------------------------------------------------------------
    // Samples mid-bit; the error pulse starts mid stop bit, inside guard time.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rx_state  <= RX_IDLE;
            rx_cnt    <= 16'h0000;
            rx_bitn   <= 3'h0;
            rx_shift  <= 8'h00;
            rx_parbit <= 1'b0;
            rx_in_q   <= 1'b1;
            rx_done   <= 1'b0;
            rx_word   <= 8'h00;
            rx_fe     <= 1'b0;
            rx_pe     <= 1'b0;
            err_drive <= 1'b0;
        end
        else
        begin
            rx_in_q <= SERIAL_IN;
            rx_done <= 1'b0;
            rx_cnt  <= rx_tick ? baud_m1 : rx_cnt - 16'h0001;
            case (rx_state)
                RX_IDLE:
                begin
                    err_drive <= 1'b0;
                    rx_cnt    <= {1'b0, baud_m1[15:1]};
                    if (rx_enable && rx_in_q && !SERIAL_IN)
                        rx_state <= RX_START;
                end
                RX_START:
                    if (rx_tick)
                    begin
                        rx_bitn  <= 3'h0;
                        rx_state <= SERIAL_IN ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_shift <= {SERIAL_IN, rx_shift[7:1]};
                        rx_bitn  <= rx_bitn + 3'h1;
                        if (rx_bitn == LAST_DATA_BIT)
                            rx_state <= parity_enable ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rx_tick)
                    begin
                        rx_parbit <= SERIAL_IN;
                        rx_state  <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                    begin
                        rx_done  <= 1'b1;
                        rx_word  <= data_invert_select ? ~rx_ordered : rx_ordered;
                        rx_fe    <= ~SERIAL_IN;
                        rx_pe    <= parity_enable & line_perr;
                        if (parity_enable && line_perr && error_signal_enable)
                        begin
                            err_drive <= 1'b1;
                            rx_state  <= RX_ERR;
                        end
                        else
                            rx_state <= RX_IDLE;
                    end
                RX_ERR:
                    if (rx_tick || rd_rx)
                    begin
                        err_drive <= 1'b0;
                        rx_state  <= RX_IDLE;
                    end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Only the error pulse can pull the line low while the transmitter idles
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            SERIAL_OUT <= 1'b1;
        else
            SERIAL_OUT <= tx_line & ~(err_drive & ~rd_rx);
    end

    // ----------------------------------------------------------------
    // Receive buffer and error flags
    // ----------------------------------------------------------------
    // A completing character beats a same-cycle read, so no event is lost.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            receive_buffer_reg <= 8'h00;
            rx_full_reg        <= 1'b0;
            overrun_reg        <= 1'b0;
            framing_reg        <= 1'b0;
            parity_err_reg     <= 1'b0;
        end
        else
        begin
            if (rd_rx)
            begin
                rx_full_reg    <= 1'b0;
                overrun_reg    <= 1'b0;
                framing_reg    <= 1'b0;
                parity_err_reg <= 1'b0;
            end
            if (rx_done && rx_full_reg && !rd_rx)
                overrun_reg <= 1'b1;
            else if (rx_done)
            begin
                receive_buffer_reg <= rx_word;
                rx_full_reg        <= 1'b1;
                framing_reg        <= rx_fe;
                parity_err_reg     <= rx_pe;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb
    begin
        irq_events              = '0;
        irq_events[IRQ_TX_BIT]  = tx_done;
        irq_events[IRQ_RX_BIT]  = rx_done & ~(rx_full_reg & ~rd_rx);
        irq_events[IRQ_ERR_BIT] = rx_done & (rx_fe | rx_pe | (rx_full_reg & ~rd_rx));
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            irq_status_reg <= '0;
            IRQ            <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (rd_stat ? '0 : irq_status_reg) | irq_events;
            IRQ            <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule // sim_card_serial_port

//--- verif/sim_card_model.sv
// Card model on the shared data line, pulling low beside the transmit pin.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/100ps
module sim_card_model
#(
    parameter int BIT_CLKS = 8
)
(
    input  wire logic clk,
    input  wire logic pin_out,
    output wire logic line
);
    logic card_bit = 1'b1;

    // Pull-up line: low while either party pulls it low
    assign line = pin_out & card_bit;

    task automatic send(input logic [7:0] w, input logic p, input logic stp);
        logic [10:0] f;
        f = {stp, p, w, 1'b0};
        for (int k = 0; k < 11; k++)
        begin
            card_bit <= f[k];
            // Good stop cut short so the guard period is watched live
            repeat ((k == 10 && stp) ? 1 : BIT_CLKS) @(posedge clk);
        end
        card_bit <= 1'b1;
    endtask
endmodule // sim_card_model

//--- verif/sim_card_serial_port_monitor.sv
// Checker for the channel's bus handshake, interrupt and pin level.
// Assumes it is bound to sim_card_serial_port and sees only its ports.
`timescale 1ns/100ps
module sim_serial_monitor
    import sim_serial_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RSTN,
    input wire logic [ADDR_W-1:0] ADDRESS,
    input wire logic              READ,
    input wire logic              WRITE,
    input wire logic [DATA_W-1:0] WRITEDATA,
    input wire logic [DATA_W-1:0] READDATA,
    input wire logic              WAITREQUEST,
    input wire logic              IRQ,
    input wire logic              SERIAL_IN,
    input wire logic              SERIAL_OUT
);
    logic [2:0]  mask_q;
    logic [15:0] baud_q;
    logic [19:0] low_cnt;
    logic        done;
    assign done = (READ || WRITE) && !WAITREQUEST;
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            mask_q  <= 3'h0;
            baud_q  <= BAUD_RESET;
            low_cnt <= 20'h0;
        end
        else
        begin
            if (done && WRITE && ADDRESS == ADDR_IRQ_MASK)
                mask_q <= WRITEDATA[2:0];
            if (done && WRITE && ADDRESS == ADDR_BAUD)
                baud_q <= (WRITEDATA[15:0] < BAUD_MIN) ? BAUD_MIN : WRITEDATA[15:0];
            low_cnt <= SERIAL_OUT ? 20'h0 : low_cnt + 20'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_req; (READ || WRITE) && WAITREQUEST; endsequence
    sequence s_ack; !WAITREQUEST ##1 WAITREQUEST; endsequence
    property p_wait_ans; s_req |=> s_ack; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("wait state not one cycle");
    property p_wait_idle; !(READ || WRITE) |=> WAITREQUEST; endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low when idle");
    property p_rd_upper; READ && !WAITREQUEST |-> READDATA[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_rd_hold; !READ |=> $stable(READDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
    property p_irq_fall; $fell(IRQ) |-> $past(done, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped with no access");
    property p_irq_mask; $past(mask_q) == 3'h0 |-> !IRQ; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt with mask clear");
    property p_irq_rise; $rose(IRQ) |-> $past(mask_q) != 3'h0; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose while masked");
    property p_low_bound; low_cnt <= 20'(baud_q) * 20'd10; endproperty
    a_low_bound: assert property (p_low_bound) else $error("pin low too long");
endmodule // sim_serial_monitor
bind sim_card_serial_port sim_serial_monitor u_mon (.CLK(CLK), .RSTN(RSTN),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT));

//--- verif/tb_sim_card_serial_port.sv
// Self-checking bench for the smart-card serial channel.
// Assumes the card model shares the pulled-up line with the transmit pin.
`timescale 1ns/100ps
module tb_sim_card_serial_port;
    import sim_serial_pkg::*;
    localparam int     BIT_CLKS = 8;
    logic              CLK;
    logic              RSTN;
    logic [ADDR_W-1:0] ADDRESS;
    logic              READ;
    logic              WRITE;
    logic [DATA_W-1:0] WRITEDATA;
    logic [DATA_W-1:0] READDATA;
    logic              WAITREQUEST;
    logic              IRQ;
    logic              SERIAL_OUT;
    wire logic         line;
    int                n_mismatch = 0;
    int                checked = 0;
    int                seed = 84;
    sim_card_serial_port u_dut (.CLK(CLK), .RSTN(RSTN), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .SERIAL_IN(line), .SERIAL_OUT(SERIAL_OUT));
    sim_card_model #(.BIT_CLKS(BIT_CLKS)) u_card (.clk(CLK), .pin_out(SERIAL_OUT),
        .line(line));
    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One idle edge first, so a release never meets a new request
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge CLK);
        READ <= !wr;
        WRITE <= wr;
        ADDRESS <= a;
        WRITEDATA <= d;
        do @(posedge CLK); while (WAITREQUEST !== 1'b0);
        q = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic wait_low(input int lim, output logic seen);
        seen = 1'b0;
        repeat (lim)
        begin
            @(posedge CLK);
            if (SERIAL_OUT === 1'b0)
            begin
                seen = 1'b1;
                break;
            end
        end
    endtask
    task automatic cfg(input logic f, input logic rx, input logic ere);
        wr(ADDR_MODE, f ? 32'h1 : 32'h3);
        wr(ADDR_CTRL0, 32'(f));
        wr(ADDR_CTRL1, (32'(!rx) << C1_TE_BIT) | (32'(rx) << C1_RE_BIT)
            | (32'(f) << C1_INV_BIT) | (32'(ere) << C1_ERE_BIT));
    endtask
    // Line image of a byte: inverse format reverses and complements
    function automatic logic [7:0] img(input logic f, input logic [7:0] d);
        logic [7:0] r;
        for (int k = 0; k < 8; k++)
            r[k] = d[7-k];
        return f ? ~r : d;
    endfunction
    task automatic wrap_up;
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        logic [7:0]  d;
        logic [8:0]  got;
        logic        f;
        logic        bad;
        logic        ere;
        logic        seen;
        RSTN = 1'b0;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = '0;
        WRITEDATA = '0;
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        bus(1'b0, ADDR_BAUD, 32'h0, q);
        chk(q, 32'(BAUD_RESET));
        bus(1'b0, ADDR_IRQ_MASK, 32'h0, q);
        chk({q[29:0], IRQ, SERIAL_OUT}, 32'h1);
        wr(ADDR_BAUD, BIT_CLKS);
        for (int i = 0; i < 2; i++)
        begin
            f = i[0];
            cfg(f, 1'b0, 1'b0);
            d = 8'($random(seed));
            wr(ADDR_TX_DATA, d);
            wait_low(8, seen);
            repeat (BIT_CLKS / 2) @(posedge CLK);
            for (int k = 0; k < 9; k++)
            begin
                repeat (BIT_CLKS) @(posedge CLK);
                got[k] = SERIAL_OUT;
            end
            chk(got, {f ^ (^img(f, d)), img(f, d)});
            repeat (2 * BIT_CLKS) @(posedge CLK);
            chk(line, 1'b1);
            bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
            chk(q[IRQ_TX_BIT], 1'b1);
        end
        for (int i = 0; i < 8; i++)
        begin
            f = i[0];
            bad = i[1];
            ere = i[2];
            cfg(f, 1'b1, ere);
            wr(ADDR_IRQ_MASK, 32'(ere) << IRQ_RX_BIT);
            d = 8'($random(seed));
            u_card.send(d, f ^ (^d) ^ bad, 1'b1);
            wait_low(3 * BIT_CLKS, seen);
            chk(seen, bad & ere);
            bus(1'b0, ADDR_RX_DATA, 32'h0, q);
            @(posedge CLK);
            chk(SERIAL_OUT, 1'b1);
            chk(q[7:0], img(f, d));
            chk(q[RX_PARITY_BIT], bad);
            chk(IRQ, ere);
            bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
            chk(q[IRQ_RX_BIT], 1'b1);
            repeat (2) @(posedge CLK);
            chk(IRQ, 1'b0);
            bus(1'b0, ADDR_RX_DATA, 32'h0, q);
            chk(q[RX_PARITY_BIT], 1'b0);
        end
        cfg(1'b0, 1'b1, 1'b0);
        u_card.send(8'h5a, 1'b0, 1'b1);
        repeat (2 * BIT_CLKS) @(posedge CLK);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        u_card.send(8'ha5, 1'b0, 1'b1);
        repeat (2 * BIT_CLKS) @(posedge CLK);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, q);
        chk(q[IRQ_RX_BIT], 1'b0);
        bus(1'b0, ADDR_RX_DATA, 32'h0, q);
        chk(q[RX_OVERRUN_BIT], 1'b1);
        u_card.send(8'h3c, 1'b0, 1'b0);
        repeat (2 * BIT_CLKS) @(posedge CLK);
        bus(1'b0, ADDR_RX_DATA, 32'h0, q);
        chk(q[RX_FRAMING_BIT], 1'b1);
        wrap_up();
    end
endmodule // tb_sim_card_serial_port
